// file: hw/smbcfg_pkg.sv
// shared constants and types for the smbus configuration block
`default_nettype none
package smbcfg_pkg;
  // register map
  localparam logic [7:0] CONFIG_ADDR = 8'hC1;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // field positions
  localparam int ENABLE_BIT = 7;
  localparam int INHIBIT_BIT = 6;
  localparam int BUSY_BIT = 5;
  localparam int HOLD_EXT_BIT = 4;
  localparam int TOE_BIT = 3;
  localparam int FTE_BIT = 2;
  localparam int CS_LSB = 0;
  // clock source encodings
  localparam logic [1:0] CS_TIMER0 = 2'h0;
  localparam logic [1:0] CS_TIMER1 = 2'h1;
  localparam logic [1:0] CS_TIMER2_HI = 2'h2;
  localparam logic [1:0] CS_TIMER2_LO = 2'h3;
  // timing, in system clocks or overflow periods
  localparam int EXT_SETUP_CYC = 11;
  localparam int EXT_HOLD_CYC = 12;
  localparam int NORM_SETUP_CYC = 1;
  localparam int NORM_HOLD_CYC = 3;
  localparam int FREE_PERIODS = 10;
  localparam int HIGH_PERIODS = 2;
  localparam int LOW_PERIODS = 1;
  localparam int CNT_W = 4;
  // configuration register layout
  typedef struct packed {
    logic interface_enable;
    logic slave_inhibit;
    logic busy;
    logic hold_extension_enable;
    logic scl_low_timeout_enable;
    logic bus_free_timeout_enable;
    logic [1:0] clock_source_select;
  } smbcfg_config_type;
  // pair of bus line levels
  typedef struct packed {
    logic scl;
    logic sda;
  } smbcfg_lines_type;
endpackage
`default_nettype wire

// file: hw/smbcfg_sync.sv
// three-stage synchroniser whose output moves once stages two and three agree
`default_nettype none
module smbcfg_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage1 feeds only stage2, so metastability never reaches logic
  always_ff @(posedge clk_i) begin
    stage1 <= async_i;
    stage2 <= stage1;
    stage3 <= stage2;
  end

  // each bit changes only when the last two stages agree
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      level_o <= INIT;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          level_o[i] <= stage3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: hw/smbcfg_line_mon.sv
// start and stop detector on the link clock, reporting each as a toggle
`default_nettype none
module smbcfg_line_mon (
  input wire logic link_clk_i,
  input wire logic link_reset_i,
  input wire smbcfg_pkg::smbcfg_lines_type pins_i,
  output logic start_toggle_o,
  output logic stop_toggle_o
);
  import smbcfg_pkg::*;
  smbcfg_lines_type lines;
  smbcfg_lines_type lines_q;

  smbcfg_sync #(.WIDTH(2), .INIT(2'h3)) u_pin_sync (
    .clk_i(link_clk_i),
    .reset_i(link_reset_i),
    .async_i(pins_i),
    .level_o(lines)
  );

  // previous line levels for edge detection
  always_ff @(posedge link_clk_i) begin
    if (link_reset_i) begin
      lines_q <= 2'h3;
    end else begin
      lines_q <= lines;
    end
  end

  // sda falling with scl high is a start, rising with scl high a stop
  always_ff @(posedge link_clk_i) begin
    if (link_reset_i) begin
      start_toggle_o <= 1'b0;
      stop_toggle_o <= 1'b0;
    end else begin
      if (lines.scl && lines_q.scl && lines_q.sda && !lines.sda) begin
        start_toggle_o <= !start_toggle_o;
      end
      if (lines.scl && lines_q.scl && !lines_q.sda && lines.sda) begin
        stop_toggle_o <= !stop_toggle_o;
      end
    end
  end
endmodule
`default_nettype wire

// file: hw/smbcfg_top.sv
// smbus configuration register with bus supervision and master clocking
`default_nettype none
module smbcfg_top (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic link_clk_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [3:0] timer_overflow_i,
  input wire logic timer3_split_i,
  output logic timer3_reload_hi_o,
  output logic timer3_reload_lo_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic start_request_i,
  input wire logic stop_request_i,
  input wire logic tx_bit_i,
  output logic bit_done_o,
  input wire logic master_event_i,
  input wire logic slave_event_i,
  output logic event_irq_o,
  output logic address_nack_o,
  output logic master_active_o,
  output logic interface_enable_o
);
  import smbcfg_pkg::*;

  typedef enum logic [2:0] {M_IDLE, M_WAIT_FREE, M_START, M_LOW, M_HIGH, M_STOP_LOW,
                            M_STOP_HIGH} smbcfg_master_type;
  smbcfg_config_type config_reg;
  smbcfg_lines_type pins, lines;
  smbcfg_master_type state;
  logic link_reset_s1, link_reset, start_toggle, stop_toggle, start_seen, stop_seen;
  logic [1:0] event_toggles, event_levels, event_levels_q;
  logic src_tick, free_timeout, inhibit_active, hold_done, setup_done;
  logic sda_drive_low, scl_drive_low;
  logic [CNT_W-1:0] free_count, phase_count, hold_count, setup_count, hold_need, setup_need;

  assign pins = '{scl: scl_i, sda: sda_i};

  // link side reset is reset_i carried over with two flops
  always_ff @(posedge link_clk_i) begin
    link_reset_s1 <= reset_i;
    link_reset <= link_reset_s1;
  end

  // start and stop detection runs on the link clock
  smbcfg_line_mon u_line_mon (
    .link_clk_i(link_clk_i),
    .link_reset_i(link_reset),
    .pins_i(pins),
    .start_toggle_o(start_toggle),
    .stop_toggle_o(stop_toggle)
  );

  // line levels enter the system domain for timers and free detection
  smbcfg_sync #(.WIDTH(2), .INIT(2'h3)) u_line_sync (
    .clk_i(ref_clk_i),
    .reset_i(reset_i),
    .async_i(pins),
    .level_o(lines)
  );

  assign event_toggles = {start_toggle, stop_toggle};

  // toggles cross as levels; a change of level is one event
  smbcfg_sync #(.WIDTH(2), .INIT(2'h0)) u_event_sync (
    .clk_i(ref_clk_i),
    .reset_i(reset_i),
    .async_i(event_toggles),
    .level_o(event_levels)
  );

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      event_levels_q <= 2'h0;
    end else begin
      event_levels_q <= event_levels;
    end
  end

  // events only count while enabled, so a disabled bus is ignored
  assign start_seen = config_reg.interface_enable && (event_levels[1] != event_levels_q[1]);
  assign stop_seen = config_reg.interface_enable && (event_levels[0] != event_levels_q[0]);

  // register write; busy is hardware only and skipped here
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      config_reg.interface_enable <= 1'b0;
      config_reg.slave_inhibit <= 1'b0;
      config_reg.hold_extension_enable <= 1'b0;
      config_reg.scl_low_timeout_enable <= 1'b0;
      config_reg.bus_free_timeout_enable <= 1'b0;
      config_reg.clock_source_select <= CS_TIMER0;
    end else if (sfr_wr_i && sfr_addr_i == CONFIG_ADDR) begin
      config_reg.interface_enable <= sfr_wdata_i[ENABLE_BIT];
      config_reg.slave_inhibit <= sfr_wdata_i[INHIBIT_BIT];
      config_reg.hold_extension_enable <= sfr_wdata_i[HOLD_EXT_BIT];
      config_reg.scl_low_timeout_enable <= sfr_wdata_i[TOE_BIT];
      config_reg.bus_free_timeout_enable <= sfr_wdata_i[FTE_BIT];
      config_reg.clock_source_select <= sfr_wdata_i[CS_LSB +: 2];
    end
  end

  // busy: a start in the same cycle as a stop wins
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      config_reg.busy <= 1'b0;
    end else if (!config_reg.interface_enable) begin
      config_reg.busy <= 1'b0;
    end else if (start_seen) begin
      config_reg.busy <= 1'b1;
    end else if (stop_seen || free_timeout) begin
      config_reg.busy <= 1'b0;
    end
  end

  // reads are combinational; unmapped addresses read zero
  assign sfr_rdata_o = (sfr_addr_i == CONFIG_ADDR) ? config_reg : 8'h00;

  // selected overflow is the pacing tick for clocks and free detection
  always_comb begin
    unique case (config_reg.clock_source_select)
      CS_TIMER0: src_tick = timer_overflow_i[0];
      CS_TIMER1: src_tick = timer_overflow_i[1];
      CS_TIMER2_HI: src_tick = timer_overflow_i[2];
      CS_TIMER2_LO: src_tick = timer_overflow_i[3];
    endcase
  end

  // free timeout fires on the eleventh tick with both lines high
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      free_count <= '0;
    end else if (!config_reg.interface_enable || !config_reg.bus_free_timeout_enable
                 || !lines.scl || !lines.sda) begin
      free_count <= '0;
    end else if (src_tick && free_count <= CNT_W'(FREE_PERIODS)) begin
      free_count <= free_count + CNT_W'(1);
    end
  end

  // one-cycle pulse as the count passes ten periods
  assign free_timeout = src_tick && free_count == CNT_W'(FREE_PERIODS)
                        && config_reg.bus_free_timeout_enable && lines.scl && lines.sda;

  // timer three held in reload while scl is high; split holds only the upper half
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      timer3_reload_hi_o <= 1'b0;
      timer3_reload_lo_o <= 1'b0;
    end else begin
      timer3_reload_hi_o <= config_reg.interface_enable
                            && config_reg.scl_low_timeout_enable && lines.scl;
      timer3_reload_lo_o <= config_reg.interface_enable && config_reg.scl_low_timeout_enable
                            && lines.scl && !timer3_split_i;
    end
  end

  // inhibit is sampled at each start so the current transfer finishes normally
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      inhibit_active <= 1'b0;
    end else if (!config_reg.interface_enable) begin
      inhibit_active <= 1'b0;
    end else if (start_seen) begin
      inhibit_active <= config_reg.slave_inhibit;
    end
  end

  // interrupt events: slave ones gated by inhibit, master ones never
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      event_irq_o <= 1'b0;
      address_nack_o <= 1'b0;
    end else begin
      event_irq_o <= config_reg.interface_enable
                     && (master_event_i || (slave_event_i && !inhibit_active));
      address_nack_o <= config_reg.interface_enable && inhibit_active;
    end
  end

  // setup and hold minimums from the extension field
  assign hold_need = config_reg.hold_extension_enable ? CNT_W'(EXT_HOLD_CYC)
                                                       : CNT_W'(NORM_HOLD_CYC);
  assign setup_need = config_reg.hold_extension_enable ? CNT_W'(EXT_SETUP_CYC)
                                                        : CNT_W'(NORM_SETUP_CYC);
  assign hold_done = hold_count >= hold_need;
  assign setup_done = setup_count >= setup_need;

  // master sequencer; leaving enable returns the state to M_IDLE at once, and the lines are released a clock later
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !config_reg.interface_enable) begin
      state <= M_IDLE;
    end else begin
      unique case (state)
        M_IDLE: begin
          if (start_request_i) begin
            state <= M_WAIT_FREE;
          end
        end
        M_WAIT_FREE: begin
          // a pending start goes out straight after the free timeout
          if (!config_reg.busy || free_timeout) begin
            state <= M_START;
          end
        end
        M_START: begin
          if (src_tick) begin
            state <= M_LOW;
          end
        end
        M_LOW: begin
          if (phase_count >= CNT_W'(LOW_PERIODS) && hold_done && setup_done) begin
            state <= M_HIGH;
          end
        end
        M_HIGH: begin
          // a slave stretching scl keeps the state in M_HIGH until release; phase_count holds at HIGH_PERIODS
          if (phase_count >= CNT_W'(HIGH_PERIODS) && lines.scl) begin
            state <= stop_request_i ? M_STOP_LOW : M_LOW;
          end
        end
        M_STOP_LOW: begin
          // the stop edge on sda needs the same setup as a data bit
          if (phase_count >= CNT_W'(LOW_PERIODS) && hold_done && setup_done) begin
            state <= M_STOP_HIGH;
          end
        end
        M_STOP_HIGH: begin
          if (phase_count >= CNT_W'(LOW_PERIODS) && lines.scl) begin
            state <= M_IDLE;
          end
        end
      endcase
    end
  end

  // overflow periods spent in the current phase
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      phase_count <= '0;
    end else if (state != smbcfg_master_type'(next_state_hint(state))) begin
      phase_count <= '0;
    end else if (src_tick && phase_count < CNT_W'(HIGH_PERIODS)) begin
      phase_count <= phase_count + CNT_W'(1);
    end
  end

  // a phase restarts when the state register is about to leave M_START, M_LOW, M_HIGH or M_STOP_LOW
  function automatic logic [2:0] next_state_hint(input smbcfg_master_type cur);
    logic [2:0] hint;
    hint = cur;
    if (cur == M_LOW && phase_count >= CNT_W'(LOW_PERIODS) && hold_done && setup_done) begin
      hint = M_HIGH;
    end
    if (cur == M_HIGH && phase_count >= CNT_W'(HIGH_PERIODS) && lines.scl) begin
      hint = M_LOW;
    end
    if (cur == M_STOP_LOW && phase_count >= CNT_W'(LOW_PERIODS) && hold_done && setup_done) begin
      hint = M_STOP_HIGH;
    end
    if (cur == M_START && src_tick) begin
      hint = M_LOW;
    end
    return hint;
  endfunction

  // hold counts system clocks from entering the low phase, setup from the sda update
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      hold_count <= '0;
      setup_count <= '0;
    end else if (state != M_LOW && state != M_STOP_LOW) begin
      hold_count <= '0;
      setup_count <= '0;
    end else if (!hold_done) begin
      hold_count <= hold_count + CNT_W'(1);
    end else if (!setup_done) begin
      setup_count <= setup_count + CNT_W'(1);
    end
  end

  // in M_LOW and M_STOP_LOW sda only moves once the hold time after scl fell has passed
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sda_drive_low <= 1'b0;
    end else begin
      unique case (state)
        M_IDLE, M_WAIT_FREE: sda_drive_low <= 1'b0;
        M_START: sda_drive_low <= 1'b1;
        M_LOW: begin
          // scl fell one clock after the count started, so wait the full count
          if (hold_count == hold_need && setup_count == '0) begin
            sda_drive_low <= !tx_bit_i;
          end
        end
        M_HIGH: sda_drive_low <= sda_drive_low;
        M_STOP_LOW: begin
          if (hold_count == hold_need && setup_count == '0) begin
            sda_drive_low <= 1'b1;
          end
        end
        M_STOP_HIGH: begin
          if (phase_count >= CNT_W'(LOW_PERIODS)) begin
            sda_drive_low <= 1'b0;
          end
        end
      endcase
    end
  end

  // scl is pulled low in the low phases, released otherwise
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      scl_drive_low <= 1'b0;
    end else begin
      scl_drive_low <= state == M_LOW || state == M_STOP_LOW;
    end
  end

  // open-drain outputs: the data pin is always 0, enable low pulls the line
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n_o = !scl_drive_low;
  assign sda_oe_n_o = !sda_drive_low;

  // status back to the shift logic
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      bit_done_o <= 1'b0;
      master_active_o <= 1'b0;
    end else begin
      bit_done_o <= state == M_HIGH && phase_count >= CNT_W'(HIGH_PERIODS) && lines.scl;
      master_active_o <= state != M_IDLE && state != M_WAIT_FREE;
    end
  end

  assign interface_enable_o = config_reg.interface_enable;
endmodule
`default_nettype wire

// file: tb/smbcfg_checker.sv
// concurrent checks on the smbus configuration block ports
`default_nettype none
module smbcfg_checker (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic timer3_split_i,
  input wire logic timer3_reload_hi_o,
  input wire logic timer3_reload_lo_o,
  input wire logic scl_i,
  input wire logic scl_oe_n_o,
  input wire logic sda_oe_n_o,
  input wire logic master_event_i,
  input wire logic slave_event_i,
  input wire logic event_irq_o,
  input wire logic master_active_o,
  input wire logic bit_done_o,
  input wire logic interface_enable_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import smbcfg_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic wr_en_q;
  // enable bit of the write data one cycle late, so it lines up with the landed write
  always_ff @(posedge ref_clk_i) begin
    wr_en_q <= sfr_wdata_i[ENABLE_BIT];
  end
  a_write_enable: assert property (sfr_wr_i && sfr_addr_i == CONFIG_ADDR
    |=> interface_enable_o == wr_en_q) else $error("enable bit differs from write");
  a_irq_cause: assert property (event_irq_o
    |-> $past(interface_enable_o) && ($past(master_event_i) || $past(slave_event_i)))
    else $error("event interrupt without an enabled event");
  a_master_irq: assert property (master_event_i && interface_enable_o |=> event_irq_o)
    else $error("master event interrupt lost");
  a_off_idle: assert property (!interface_enable_o [*3]
    |-> scl_oe_n_o && sda_oe_n_o && !master_active_o) else $error("bus driven while off");
  a_reload_pair: assert property (timer3_reload_lo_o |-> timer3_reload_hi_o)
    else $error("low half reload without high half");
  a_reload_en: assert property (timer3_reload_hi_o |-> $past(interface_enable_o))
    else $error("reload while interface off");
  a_split_low: assert property (timer3_split_i [*2] |-> !timer3_reload_lo_o)
    else $error("low half held in split mode");
  a_scl_low_count: assert property (!scl_i [*8] |-> !timer3_reload_hi_o)
    else $error("timer held in reload while clock line low");
  a_sda_hold: assert property ($fell(scl_oe_n_o) |-> $stable(sda_oe_n_o) [*3])
    else $error("data hold too short");
  a_sda_setup: assert property ($rose(scl_oe_n_o) |-> $stable(sda_oe_n_o))
    else $error("data moved at clock release");
  c_bit_done: cover property (bit_done_o);
  c_slave_irq: cover property (slave_event_i && interface_enable_o ##1 event_irq_o);
  c_split: cover property (timer3_reload_hi_o && !timer3_reload_lo_o);
endmodule
`default_nettype wire

// file: tb/smbcfg_bus_model.sv
// far-side bus party making start and stop conditions on the open-drain wire
`default_nettype none
module smbcfg_bus_model (
  output logic scl_oe_n_o,
  output logic sda_oe_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // released lines go to the pull-up level; step sets how slow the party is
  initial begin
    scl_oe_n_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  // start, then one clock pulse that leaves both lines high without a stop
  task automatic start_idle(input int step);
    sda_oe_n_o = 1'b0;
    #step;
    scl_oe_n_o = 1'b0;
    #step;
    sda_oe_n_o = 1'b1;
    #step;
    scl_oe_n_o = 1'b1;
    #step;
  endtask
  // data rises while the clock is high
  task automatic stop_cond(input int step);
    scl_oe_n_o = 1'b0;
    #step;
    sda_oe_n_o = 1'b0;
    #step;
    scl_oe_n_o = 1'b1;
    #step;
    sda_oe_n_o = 1'b1;
    #step;
  endtask
endmodule
`default_nettype wire

// file: tb/smbcfg_top_tb.sv
// self-checking testbench for the smbus configuration block
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module smbcfg_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import smbcfg_pkg::*;
  logic ref_clk_i, reset_i, link_clk_i, sfr_wr_i, timer3_split_i, start_request_i;
  logic stop_request_i, tx_bit_i, master_event_i, slave_event_i, scl_o, sda_o, done;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, rd;
  logic [3:0] timer_overflow_i;
  logic timer3_reload_hi_o, timer3_reload_lo_o, scl_oe_n_o, sda_oe_n_o, bit_done_o;
  logic event_irq_o, address_nack_o, master_active_o, interface_enable_o;
  logic model_scl_oe_n, model_sda_oe_n, scl_line, sda_line;
  int miscompares, n_tests, i, cs;
  // open-drain wires with pull-ups: low while any party drives
  assign scl_line = scl_oe_n_o & model_scl_oe_n;
  assign sda_line = sda_oe_n_o & model_sda_oe_n;
  smbcfg_top smbcfg_top_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .link_clk_i(link_clk_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .timer_overflow_i(timer_overflow_i),
    .timer3_split_i(timer3_split_i), .timer3_reload_hi_o(timer3_reload_hi_o),
    .timer3_reload_lo_o(timer3_reload_lo_o), .scl_i(scl_line), .scl_o(scl_o),
    .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .start_request_i(start_request_i), .stop_request_i(stop_request_i),
    .tx_bit_i(tx_bit_i), .bit_done_o(bit_done_o), .master_event_i(master_event_i),
    .slave_event_i(slave_event_i), .event_irq_o(event_irq_o),
    .address_nack_o(address_nack_o), .master_active_o(master_active_o),
    .interface_enable_o(interface_enable_o));
  smbcfg_bus_model bus_model_inst (.scl_oe_n_o(model_scl_oe_n), .sda_oe_n_o(model_sda_oe_n));
  // system clock and an unrelated link sampling clock
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7.3;
    forever #32 link_clk_i = ~link_clk_i;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_wr_i <= 1'b0;
  endtask
  // read data is combinational, so sample once the address has settled
  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    @(posedge ref_clk_i);
    #1 rd = sfr_rdata_o;
  endtask
  task automatic ev(input logic slave, input logic exp);
    @(posedge ref_clk_i);
    master_event_i <= !slave;
    slave_event_i <= slave;
    @(posedge ref_clk_i);
    master_event_i <= 1'b0;
    slave_event_i <= 1'b0;
    #1 `CHK(event_irq_o, exp)
  endtask
  // one overflow pulse every eight system clocks on the chosen source
  task automatic tick(input int src, input int n);
    repeat (n) begin
      repeat (7) @(posedge ref_clk_i);
      timer_overflow_i[src] <= 1'b1;
      @(posedge ref_clk_i);
      timer_overflow_i <= 4'h0;
    end
  endtask
  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
  initial begin
    reset_i = 1'b1;
    sfr_addr_i = 8'h00;
    sfr_wr_i = 1'b0;
    sfr_wdata_i = 8'h00;
    timer_overflow_i = 4'h0;
    timer3_split_i = 1'b0;
    start_request_i = 1'b0;
    stop_request_i = 1'b0;
    tx_bit_i = 1'b0;
    master_event_i = 1'b0;
    slave_event_i = 1'b0;
    // held forty cycles so the link side sees three of its edges
    repeat (40) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rdr(CONFIG_ADDR);
    `CHK(rd, CONFIG_RESET)
    // busy ignores writes; unmapped places read zero and leave the register alone
    wr(CONFIG_ADDR, 8'hFF);
    rdr(CONFIG_ADDR);
    `CHK(rd, 8'hDF)
    wr(8'h55, 8'h3C);
    rdr(8'h55);
    `CHK(rd, 8'h00)
    rdr(CONFIG_ADDR);
    `CHK(rd, 8'hDF)
    repeat (10) @(posedge ref_clk_i);
    #1 `CHK({timer3_reload_hi_o, timer3_reload_lo_o}, 2'b11)
    @(posedge ref_clk_i);
    timer3_split_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK({timer3_reload_hi_o, timer3_reload_lo_o}, 2'b10)
    @(posedge ref_clk_i);
    timer3_split_i <= 1'b0;
    wr(CONFIG_ADDR, 8'h00);
    // slave events gated by inhibit only from the next start
    wr(CONFIG_ADDR, 8'h80);
    ev(1'b1, 1'b1);
    wr(CONFIG_ADDR, 8'hC0);
    ev(1'b1, 1'b1);
    bus_model_inst.start_idle(300);
    repeat (80) @(posedge ref_clk_i);
    rdr(CONFIG_ADDR);
    `CHK(rd[BUSY_BIT], 1'b1)
    ev(1'b1, 1'b0);
    ev(1'b0, 1'b1);
    `CHK(address_nack_o, 1'b1)
    bus_model_inst.stop_cond(300);
    repeat (80) @(posedge ref_clk_i);
    rdr(CONFIG_ADDR);
    `CHK(rd, 8'hC0)
    wr(CONFIG_ADDR, 8'h00);
    ev(1'b0, 1'b0);
    // free timeout counts only the selected source, clearing on the eleventh tick
    for (cs = 0; cs < 4; cs++) begin
      wr(CONFIG_ADDR, 8'h84 | 8'(cs));
      bus_model_inst.start_idle(120 + 100 * cs);
      repeat (80) @(posedge ref_clk_i);
      tick((cs + 1) % 4, 12);
      tick(cs, FREE_PERIODS);
      rdr(CONFIG_ADDR);
      `CHK(rd[BUSY_BIT], 1'b1)
      tick(cs, 1);
      repeat (10) @(posedge ref_clk_i);
      rdr(CONFIG_ADDR);
      `CHK(rd[BUSY_BIT], 1'b0)
    end
    // master start held back by a busy bus, extended hold, timer0 pacing
    wr(CONFIG_ADDR, 8'h9C);
    bus_model_inst.start_idle(300);
    repeat (80) @(posedge ref_clk_i);
    start_request_i <= 1'b1;
    tx_bit_i <= 1'b1;
    tick(0, FREE_PERIODS);
    `CHK(sda_oe_n_o, 1'b1)
    done = 1'b0;
    fork
      tick(0, 60);
      begin
        for (i = 0; i < 100 && sda_oe_n_o !== 1'b0; i++) @(posedge ref_clk_i);
        `CHK(sda_oe_n_o, 1'b0)
        start_request_i <= 1'b0;
        for (i = 0; i < 200 && scl_oe_n_o !== 1'b0; i++) @(posedge ref_clk_i);
        for (i = 0; i < 300 && sda_oe_n_o === 1'b0; i++) @(posedge ref_clk_i);
        `CHK(i >= EXT_HOLD_CYC, 1'b1)
        for (; i < 300 && scl_oe_n_o === 1'b0; i++) @(posedge ref_clk_i);
        `CHK(i >= EXT_HOLD_CYC + EXT_SETUP_CYC, 1'b1)
        for (i = 0; i < 300 && scl_oe_n_o === 1'b1; i++) begin
          done = done | (bit_done_o === 1'b1);
          @(posedge ref_clk_i);
        end
        `CHK(i >= 16, 1'b1)
        `CHK(done, 1'b1)
        stop_request_i <= 1'b1;
        for (i = 0; i < 400 && master_active_o !== 1'b0; i++) @(posedge ref_clk_i);
        `CHK({master_active_o, scl_oe_n_o, sda_oe_n_o}, 3'b011)
        stop_request_i <= 1'b0;
      end
    join
    wr(CONFIG_ADDR, 8'h00);
    rdr(CONFIG_ADDR);
    `CHK(rd, 8'h00)
    `CHK({scl_o, sda_o}, 2'b00)
    stop_test();
  end
endmodule
bind smbcfg_top smbcfg_checker smbcfg_checker_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
  .timer3_split_i(timer3_split_i), .timer3_reload_hi_o(timer3_reload_hi_o),
  .timer3_reload_lo_o(timer3_reload_lo_o), .scl_i(scl_i), .scl_oe_n_o(scl_oe_n_o),
  .sda_oe_n_o(sda_oe_n_o), .master_event_i(master_event_i), .slave_event_i(slave_event_i),
  .event_irq_o(event_irq_o), .master_active_o(master_active_o), .bit_done_o(bit_done_o),
  .interface_enable_o(interface_enable_o));
`default_nettype wire
